/* File: hdl/sap_ctrl.sv */
/*
 * sap_ctrl: host port and sequencing for a 12-bit SAR converter.
 * Assumes the host strobes and the conversion clock pin are asynchronous
 * and are synchronised here; the analog side gives a comparator answer.
 */
`timescale 1ns/1ps
module sap_ctrl (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_cs_n,
    input wire logic i_rd_n,
    input wire logic i_wr_n,
    input wire logic i_conv_clk,
    input wire logic [7:0] i_data_in,
    input wire logic i_cmp_high,
    output logic [11:0] o_data_out,
    output logic [11:0] o_data_oe_n,
    output logic o_done_n,
    output logic o_done_oe_n,
    output logic [5:0] o_pos_select,
    output logic [5:0] o_neg_select,
    output logic o_neg_common,
    output logic o_track,
    output logic o_unipolar,
    output logic o_powered,
    output logic o_standby,
    output logic [11:0] o_dac_code
);
    // ------------------------------------------------------------
    // pin synchronisers: first stage is read only by the second
    // ------------------------------------------------------------
    logic [3:0] s1_r, s2_r, s3_r;
    logic [7:0] din1_r, din2_r;
    // clock pin bit presets low: a static pin at either level then gives
    // no false falling edge after reset
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            s1_r <= 4'hE;
            s2_r <= 4'hE;
            s3_r <= 4'hE;
            din1_r <= 8'h00;
            din2_r <= 8'h00;
        end else begin
            s1_r <= {i_cs_n, i_rd_n, i_wr_n, i_conv_clk};
            s2_r <= s1_r;
            s3_r <= s2_r;
            din1_r <= i_data_in; // host holds the byte across the write
            din2_r <= din1_r;
        end
    end
    logic cs_n, rd_fall, wr_rise, eclk_fall;
    assign cs_n = s2_r[3];
    assign rd_fall = s3_r[2] & ~s2_r[2];
    assign wr_rise = ~s3_r[1] & s2_r[1];
    assign eclk_fall = s3_r[0] & ~s2_r[0];

    // ------------------------------------------------------------
    // internal clock divider; falling edge is the enable pulse
    // ------------------------------------------------------------
    logic [1:0] div_r, div_nxt;
    logic iclk_fall;
    assign div_nxt = (div_r == sap_pkg::INT_DIV_MAX) ? 2'h0 : div_r + 2'h1;
    always_ff @(posedge i_clk) begin
        if (!i_rstn) div_r <= 2'h0;
        else div_r <= div_nxt;
    end
    assign iclk_fall = (div_r == sap_pkg::INT_DIV_MAX);

    // ------------------------------------------------------------
    // main sequencer
    // ------------------------------------------------------------
    sap_pkg::sap_state_e st_r, st_nxt;
    logic [7:0] ctrl_r, ctrl_nxt;
    logic [2:0] edges_r, edges_nxt;
    logic done_n_r, done_n_nxt, drive_r, drive_nxt;
    logic [11:0] data_r, data_nxt;
    logic step, start, sar_done;
    logic [11:0] sar_res;
    logic ext_clk_mode, wr_ok;

    assign ext_clk_mode = (ctrl_r[7:6] == sap_pkg::PWR_EXT_CLK);
    // in external mode the host clock paces the acquisition edges and the sar steps
    assign step = ext_clk_mode ? eclk_fall : iclk_fall;
    assign wr_ok = wr_rise & ~cs_n;
    // the sar is armed as the hold switch opens
    assign start = (st_r != sap_pkg::SAP_CONV) && (st_nxt == sap_pkg::SAP_CONV);

    always_comb begin
        st_nxt = st_r;
        ctrl_nxt = ctrl_r;
        edges_nxt = edges_r;
        done_n_nxt = done_n_r;
        drive_nxt = drive_r;
        data_nxt = data_r;
        if (cs_n) drive_nxt = 1'b0;
        else if (rd_fall) begin
            drive_nxt = 1'b1;
            done_n_nxt = 1'b1;
        end
        unique case (st_r)
            sap_pkg::SAP_IDLE, sap_pkg::SAP_DONE: begin
                if (wr_ok) begin
                    ctrl_nxt = din2_r;
                    edges_nxt = 3'h0;
                    if (din2_r[sap_pkg::PWR_HI] == 1'b0)
                        st_nxt = sap_pkg::SAP_IDLE;
                    else if (din2_r[sap_pkg::ACQ_BIT])
                        st_nxt = sap_pkg::SAP_ACQ_EXT;
                    else
                        st_nxt = sap_pkg::SAP_ACQ_INT;
                end
            end
            sap_pkg::SAP_ACQ_INT: begin
                if (step) begin
                    edges_nxt = edges_r + 3'h1;
                    if (edges_r + 3'h1 == sap_pkg::ACQ_EDGES_C)
                        st_nxt = sap_pkg::SAP_CONV;
                end
            end
            sap_pkg::SAP_ACQ_EXT: begin
                if (wr_ok) st_nxt = sap_pkg::SAP_CONV;
            end
            sap_pkg::SAP_CONV: begin
                if (sar_done) begin
                    data_nxt = sar_res;
                    done_n_nxt = 1'b0;
                    st_nxt = sap_pkg::SAP_DONE;
                end
            end
            default: st_nxt = sap_pkg::SAP_IDLE;
        endcase
        // a new control write clears the old completion flag
        if (wr_ok && (st_r == sap_pkg::SAP_IDLE || st_r == sap_pkg::SAP_DONE))
            done_n_nxt = 1'b1;
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            st_r <= sap_pkg::SAP_IDLE;
            ctrl_r <= sap_pkg::CTRL_RESET;
            edges_r <= 3'h0;
            done_n_r <= 1'b1;
            drive_r <= 1'b0;
            data_r <= 12'h000;
        end else begin
            st_r <= st_nxt;
            ctrl_r <= ctrl_nxt;
            edges_r <= edges_nxt;
            done_n_r <= done_n_nxt;
            drive_r <= drive_nxt;
            data_r <= data_nxt;
        end
    end

    sap_sar u_sar (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_start(start),
        .i_step(step && st_r == sap_pkg::SAP_CONV),
        .i_cmp_high(i_cmp_high),
        .o_trial(o_dac_code),
        .o_result(sar_res),
        .o_done(sar_done)
    );

    // ------------------------------------------------------------
    // input multiplexer: one select line per analog channel
    // ------------------------------------------------------------
    logic [2:0] adr, neg_ch;
    logic sgl;
    assign adr = ctrl_r[sap_pkg::ADR_HI:0];
    assign sgl = ctrl_r[sap_pkg::CFG_BIT];
    // pairs: 2 with 3, 4 with 5; codes 0,1,3 have no partner
    always_comb begin
        unique case (adr)
            3'h2: neg_ch = 3'h3;
            3'h4: neg_ch = 3'h5;
            3'h5: neg_ch = 3'h4;
            default: neg_ch = sap_pkg::CH_NONE;
        endcase
    end
    genvar g;
    generate
        for (g = 0; g < sap_pkg::CHANNELS; g++) begin : g_mux
            assign o_pos_select[g] = (adr == 3'(g));
            assign o_neg_select[g] = !sgl && (neg_ch == 3'(g));
        end
    endgenerate
    assign o_neg_common = sgl;
    assign o_track = (st_r == sap_pkg::SAP_ACQ_INT) ||
                     (st_r == sap_pkg::SAP_ACQ_EXT);
    assign o_unipolar = ctrl_r[sap_pkg::POL_BIT];
    assign o_powered = ctrl_r[sap_pkg::PWR_HI];
    assign o_standby = (ctrl_r[7:6] == sap_pkg::PWR_STANDBY);

    // ------------------------------------------------------------
    // pins: enables are low while driving
    // ------------------------------------------------------------
    assign o_data_out = data_r;
    assign o_data_oe_n = {12{~drive_r}};
    assign o_done_n = done_n_r;
    assign o_done_oe_n = cs_n;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_done_low;
        @(posedge i_clk) disable iff (!i_rstn)
        sar_done && st_r == sap_pkg::SAP_CONV |=> !o_done_n && o_data_out == $past(sar_res);
    endproperty
    a_done_low: assert property (p_done_low) else $error("flag not low");
    property p_read;
        @(posedge i_clk) disable iff (!i_rstn)
        !cs_n && rd_fall |=> o_data_oe_n == 12'h000;
    endproperty
    a_read: assert property (p_read) else $error("read not driven");
    property p_float;
        @(posedge i_clk) disable iff (!i_rstn)
        cs_n |-> o_done_oe_n ##1 o_data_oe_n == 12'hFFF;
    endproperty
    a_float: assert property (p_float) else $error("bus not floated");
    property p_int_acq;
        @(posedge i_clk) disable iff (!i_rstn)
        st_r == sap_pkg::SAP_IDLE && wr_ok && din2_r[7:5] == 3'h4
        |=> st_r == sap_pkg::SAP_ACQ_INT && ctrl_r == $past(din2_r);
    endproperty
    a_int_acq: assert property (p_int_acq) else $error("no acquire");
    property p_ext_acq;
        @(posedge i_clk) disable iff (!i_rstn)
        st_r == sap_pkg::SAP_ACQ_EXT && wr_ok |=> st_r == sap_pkg::SAP_CONV;
    endproperty
    a_ext_acq: assert property (p_ext_acq) else $error("no convert");
    property p_fourth;
        @(posedge i_clk) disable iff (!i_rstn)
        st_r == sap_pkg::SAP_ACQ_INT && step && edges_r == 3'h3
        |=> !o_track;
    endproperty
    a_fourth: assert property (p_fourth) else $error("hold late");
    property p_early;
        @(posedge i_clk) disable iff (!i_rstn)
        st_r == sap_pkg::SAP_ACQ_INT && edges_r < 3'h3 |=> o_track;
    endproperty
    a_early: assert property (p_early) else $error("hold early");
    property p_sgl;
        @(posedge i_clk) disable iff (!i_rstn)
        sgl |-> o_neg_common && o_neg_select == 6'h00 &&
            $onehot(o_pos_select) == (adr <= sap_pkg::CH_LAST);
    endproperty
    a_sgl: assert property (p_sgl) else $error("single mux");
    property p_dif;
        @(posedge i_clk) disable iff (!i_rstn)
        !sgl && adr == 3'h4 |-> o_neg_select == 6'h20 && !o_neg_common;
    endproperty
    a_dif: assert property (p_dif) else $error("pair mux");
    property p_pwr;
        @(posedge i_clk) disable iff (!i_rstn)
        st_r == sap_pkg::SAP_IDLE && wr_ok && !din2_r[7]
        |=> st_r == sap_pkg::SAP_IDLE && !o_powered;
    endproperty
    a_pwr: assert property (p_pwr) else $error("power down");
endmodule : sap_ctrl

/* File: hdl/sap_sar.sv */
/*
 * sap_sar: twelve-bit successive approximation sequencer.
 * Assumes one step enable per conversion clock and an external comparator
 * whose answer is valid in the cycle the step enable is high.
 */
`timescale 1ns/1ps
module sap_sar (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_start,
    input wire logic i_step,
    input wire logic i_cmp_high,
    output logic [11:0] o_trial,
    output logic [11:0] o_result,
    output logic o_done
);
    logic [11:0] trial_r, trial_nxt, mask_r, mask_nxt, res_r, res_nxt;
    logic done_r, done_nxt;

    // ------------------------------------------------------------
    // bit trial: keep the bit when the comparator says input is higher
    // ------------------------------------------------------------
    always_comb begin
        logic [11:0] kept;
        kept = 12'h000;
        trial_nxt = trial_r;
        mask_nxt = mask_r;
        res_nxt = res_r;
        done_nxt = 1'b0;
        if (i_start) begin
            mask_nxt = 12'h800;
            trial_nxt = 12'h800;
        end else if (i_step && mask_r != 12'h000) begin
            kept = i_cmp_high ? trial_r : (trial_r & ~mask_r);
            mask_nxt = mask_r >> 1;
            trial_nxt = kept | (mask_r >> 1);
            if (mask_r == 12'h001) begin
                res_nxt = kept;
                done_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            trial_r <= 12'h000;
            mask_r <= 12'h000;
            res_r <= 12'h000;
            done_r <= 1'b0;
        end else begin
            trial_r <= trial_nxt;
            mask_r <= mask_nxt;
            res_r <= res_nxt;
            done_r <= done_nxt;
        end
    end

    assign o_trial = trial_r;
    assign o_result = res_r;
    assign o_done = done_r;
endmodule : sap_sar

/* File: inc/sap_pkg.sv */
/*
 * sap_pkg: constants shared by the converter control logic.
 * Assumes a 10 MHz system clock and plain ports, no register bus.
 */
package sap_pkg;
    // ------------------------------------------------------------
    // control byte fields
    // ------------------------------------------------------------
    localparam int PWR_HI = 7;
    localparam int PWR_LO = 6;
    localparam int ACQ_BIT = 5;
    localparam int CFG_BIT = 4;
    localparam int POL_BIT = 3;
    localparam int ADR_HI = 2;
    localparam logic [1:0] PWR_FULL_DOWN = 2'h0;
    localparam logic [1:0] PWR_STANDBY = 2'h1;
    localparam logic [1:0] PWR_INT_CLK = 2'h2;
    localparam logic [1:0] PWR_EXT_CLK = 2'h3;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    // ------------------------------------------------------------
    // widths and timing
    // ------------------------------------------------------------
    localparam int RES_BITS = 12;
    localparam int CHANNELS = 6;
    localparam int ACQ_EDGES = 4;
    localparam logic [3:0] RES_BITS_C = 4'hC;
    localparam logic [2:0] ACQ_EDGES_C = 3'h4;
    localparam int INT_CLK_DIV = 2;
    localparam logic [1:0] INT_DIV_MAX = 2'h1;
    localparam logic [2:0] CH_NONE = 3'h7;
    localparam logic [2:0] CH_LAST = 3'h5;
    typedef enum logic [2:0] {
        SAP_IDLE, SAP_ACQ_INT, SAP_ACQ_EXT, SAP_CONV, SAP_DONE
    } sap_state_e;
endpackage : sap_pkg

/* File: testbench/sap_host.sv */
/* sap_host: host processor model on the strobe bus and clock pin.
   assumes the bench clock; strobes and data move 1 ns after its edge, the clock pin on its own 240 ns timer. */
`timescale 1ns/1ps
module sap_host (
    input wire logic i_clk,
    input wire logic [11:0] i_data,
    input wire logic [11:0] i_data_oe_n,
    output logic o_cs_n,
    output logic o_rd_n,
    output logic o_wr_n,
    output logic o_conv_clk,
    output logic [7:0] o_data
);
    logic clk_run;
    initial begin
        clk_run = 1'b0;
        o_conv_clk = 1'b0;
        o_cs_n = 1'b1;
        o_rd_n = 1'b1;
        o_wr_n = 1'b1;
        o_data = 8'hA5;
    end
    // pin runs only while ext clock mode is wanted, static at its last level otherwise
    // half period of 240 ns never lands on a rising bench clock edge
    always #240 if (clk_run) o_conv_clk = ~o_conv_clk;
    // strobes held 3 cycles (write) or 4 cycles (read) so that the 2-ff syncs see them
    task automatic write_byte(input logic [7:0] b);
        @(posedge i_clk) #1;
        o_cs_n = 1'b0;
        o_data = b;
        repeat (3) @(posedge i_clk);
        #1 o_wr_n = 1'b0;
        repeat (3) @(posedge i_clk);
        #1 o_wr_n = 1'b1;
        repeat (4) @(posedge i_clk);
        #1 o_data = ~b; // released bus must not show the old byte
    endtask : write_byte
    task automatic read_word(output logic [11:0] w, output logic [11:0] oe);
        @(posedge i_clk) #1;
        o_cs_n = 1'b0;
        repeat (3) @(posedge i_clk);
        #1 o_rd_n = 1'b0;
        repeat (4) @(posedge i_clk);
        w = i_data;
        oe = i_data_oe_n;
        #1 o_rd_n = 1'b1;
        repeat (3) @(posedge i_clk);
        #1 o_cs_n = 1'b1;
        repeat (4) @(posedge i_clk);
    endtask : read_word
endmodule : sap_host

/* File: testbench/sar_adc_parallel_host_port_tb.sv */
/* sar_adc_parallel_host_port_tb: self-checking bench for sap_ctrl.
   assumes a behavioural sample-hold and comparator on 12-bit codes. */
`timescale 1ns/1ps
`define CHK(got, exp, msg) begin tests_run++; \
    if ((got) !== (exp)) begin n_mismatch++; \
    $display("mismatch at %0t: %s", $time, msg); end end
module sar_adc_parallel_host_port_tb;
    logic i_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic cs_n, rd_n, wr_n, conv_clk, cmp_high;
    logic [7:0] data_in;
    logic [11:0] data_out, data_oe_n, dac_code, vin;
    logic [11:0] held = 12'h000;
    logic done_n, done_oe_n, neg_common, track, unipolar, powered, standby;
    logic [5:0] pos_sel, neg_sel;
    logic [11:0] ch_v [6] = '{12'h000, 12'hFFF, 12'hA5A, 12'h5A5,
        12'h800, 12'h7FF};
    logic [5:0] neg_tab [6] = '{6'h00, 6'h00, 6'h08, 6'h00, 6'h20, 6'h10};
    int n_mismatch = 0;
    int tests_run = 0;
    int cyc = 0;
    int trk_cnt = 0;
    always #50 i_clk = ~i_clk;
    sap_ctrl dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_cs_n(cs_n),
        .i_rd_n(rd_n), .i_wr_n(wr_n), .i_conv_clk(conv_clk),
        .i_data_in(data_in), .i_cmp_high(cmp_high), .o_data_out(data_out),
        .o_data_oe_n(data_oe_n), .o_done_n(done_n), .o_done_oe_n(done_oe_n),
        .o_pos_select(pos_sel), .o_neg_select(neg_sel),
        .o_neg_common(neg_common), .o_track(track), .o_unipolar(unipolar),
        .o_powered(powered), .o_standby(standby), .o_dac_code(dac_code));
    sap_host host (.i_clk(i_clk), .i_data(data_out), .i_data_oe_n(data_oe_n),
        .o_cs_n(cs_n), .o_rd_n(rd_n), .o_wr_n(wr_n), .o_conv_clk(conv_clk),
        .o_data(data_in));
    // ------------
    // analog side
    // ------------
    // the return input is taken as ground, so only the plus channel counts
    always_comb begin
        vin = 12'h000;
        for (int i = 0; i < 6; i++)
            if (pos_sel[i] === 1'b1) vin = ch_v[i];
    end
    always @(posedge i_clk) if (track === 1'b1) held <= vin;
    // half-step offset keeps the expected code free of ties
    assign cmp_high = {held, 1'b1} > {dac_code, 1'b0};
    // tracking length and a ceiling on the whole run
    always @(posedge i_clk) begin
        cyc++;
        if (track === 1'b1) trk_cnt++;
        if (cyc == 5000) begin
            n_mismatch++;
            wrap_up();
        end
    end
    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : wrap_up
    // ------------
    // scenarios
    // ------------
    task automatic run_conv(input logic [7:0] b, input logic [11:0] exp,
            input logic [12:0] sel);
        logic [11:0] w, oe;
        int n;
        trk_cnt = 0;
        host.write_byte(b);
        `CHK({pos_sel, neg_sel, neg_common}, sel, "input select")
        if (b[5]) begin
            repeat (40) @(posedge i_clk);
            #1 `CHK(track, 1'b1, "acquisition ended early")
            `CHK(done_n, 1'b1, "converted before second write")
            host.write_byte(b & 8'hDF);
        end
        n = 0;
        while (done_n !== 1'b0 && n < 400) begin
            @(posedge i_clk);
            n++;
        end
        #1 `CHK(done_n, 1'b0, "no completion flag")
        if (b[7:5] == 3'h4) `CHK(trk_cnt inside {[6:9]}, 1'b1, "hold")
        host.read_word(w, oe);
        `CHK(w, exp, "result word")
        `CHK(oe, 12'h000, "bus not driven in read")
        `CHK(done_n, 1'b1, "flag not cleared by read")
        `CHK({data_oe_n, done_oe_n}, 13'h1FFF, "driven with cs high")
    endtask : run_conv
    task automatic t_reset();
        `CHK({data_oe_n, done_oe_n, done_n}, 14'h3FFF, "reset pins")
        `CHK({powered, track}, 2'h0, "reset state")
        $display("test reset done");
    endtask : t_reset
    task automatic t_single();
        for (int c = 0; c < 6; c++) begin
            run_conv(8'h98 | 8'(c), ch_v[c], {6'h01 << c, 6'h00, 1'b1});
            `CHK({powered, standby, unipolar}, 3'h5, "mode bits")
        end
        $display("test single-ended done");
    endtask : t_single
    task automatic t_diff();
        for (int a = 0; a < 6; a++)
            run_conv(8'h88 | 8'(a), ch_v[a], {6'h01 << a, neg_tab[a], 1'b0});
        $display("test pseudo-differential done");
    endtask : t_diff
    task automatic t_ext();
        run_conv(8'hBB, ch_v[3], {6'h08, 6'h00, 1'b1});
        host.clk_run = 1'b1;
        run_conv(8'hD9, ch_v[1], {6'h02, 6'h00, 1'b1});
        host.clk_run = 1'b0;
        $display("test external modes done");
    endtask : t_ext
    task automatic t_power();
        host.write_byte(8'h00);
        repeat (60) @(posedge i_clk);
        #1 `CHK({powered, standby, done_n}, 3'h1, "full power-down")
        host.write_byte(8'h40);
        `CHK(standby, 1'b1, "standby")
        run_conv(8'h92, ch_v[2], {6'h04, 6'h00, 1'b1});
        `CHK(unipolar, 1'b0, "bipolar coding bit")
        $display("test power modes done");
    endtask : t_power
    initial begin
        repeat (20) @(posedge i_clk);
        #1 i_rstn = 1'b1;
        t_reset();
        t_single();
        t_diff();
        t_ext();
        t_power();
        wrap_up();
    end
endmodule : sar_adc_parallel_host_port_tb
